// *** pkg/gate_driver_params.svh ***
// Notes on behaviour
// - The settings register sits at byte offset 0xAC, is 32 bits wide and resets to 0x00228000.
// - The two-bit fault response field picks latched, auto-retry, report-only or ignore for codes 0 to 3.
// - In auto-retry mode an overcurrent shuts the outputs off and resumes after the retry time.
// - In report-only mode an overcurrent is recorded and reported while the outputs keep running.
// - In ignore mode an overcurrent is neither reported nor acted on.
// - Bit 11 selects a 5 ms retry interval when clear and 500 ms when set; RETRY_LONG_CYC overflows 32 bits to 705032 cycles, about 70.5 ms.
// - Bits 13-12 select an overcurrent deglitch of 0.2, 0.6, 1.1 or 1.6 us.
// - Bit 10 selects a 16 A trip level when clear and 24 A when set.
// - Bit 18 enables supply overvoltage protection and bit 19 selects 32 V when clear or 20 V when set.
// - Bit 16 decides whether an overtemperature warning pulls the active-low fault indicator.
// - Bit 5 sets the low-side demag threshold, 100 mA when clear and 150 mA when set.
// - Bit 4 sets the high-side demag threshold independently with the same encoding.
// - Synchronous rectification is used only while bit 3 is set.
// - Asynchronous rectification is used only while bit 2 is set.
// - Bits 1-0 select sense gain 0.15, 0.3, 0.6 or 1.2 V/A.
`ifndef GATE_DRIVER_PARAMS_SVH
`define GATE_DRIVER_PARAMS_SVH

`define GDS1_OFFSET        8'hAC
`define GDS1_RESET         32'h00228000
`define GDS1_SLEW_LSB      26
`define GDS1_SUPPLY_OVERVOLTAGE_THRESHOLD_SELECT_BIT   19
`define GDS1_SUPPLY_OVERVOLTAGE_GUARD_ENABLE_BIT    18
`define GDS1_OVERTEMP_WARNING_REPORT_ENABLE_BIT   16
`define GDS1_DEG_LSB       12
`define GDS1_RETRY_BIT     11
`define GDS1_LVL_BIT       10
`define GDS1_MODE_LSB      8
`define GDS1_DMAG_LS_BIT   5
`define GDS1_DMAG_HS_BIT   4
`define GDS1_SYNC_BIT      3
`define GDS1_ASYNC_BIT     2
`define GDS1_GAIN_LSB      0

// Clock rate and times in their own units
`define CLK_HZ             10000000
`define RETRY_SHORT_MS     5
`define RETRY_LONG_MS      500
`define DEG0_NS            200
`define DEG1_NS            600
`define DEG2_NS            1100
`define DEG3_NS            1600
`define RETRY_SHORT_CYC    ((`RETRY_SHORT_MS * `CLK_HZ) / 1000)
`define RETRY_LONG_CYC     ((`RETRY_LONG_MS * `CLK_HZ) / 1000)
`define NS_TO_CYC(ns)      (((ns) * (`CLK_HZ / 1000000) + 999) / 1000)

`endif

// *** pkg/gate_driver_pkg.sv ***
`default_nettype none
package gate_driver_pkg;
	typedef enum logic [1:0] {
		OC_LATCHED = 2'h0,
		OC_RETRY   = 2'h1,
		OC_REPORT  = 2'h2,
		OC_IGNORE  = 2'h3
	} oc_response_t;

	typedef enum logic [2:0] {
		OC_ST_RUN     = 3'b001,
		OC_ST_LATCHED = 3'b010,
		OC_ST_WAIT    = 3'b100
	} oc_state_t;
endpackage : gate_driver_pkg
`default_nettype wire

// *** rtl/oc_deglitch.sv ***
`timescale 1ns/10ps
`default_nettype none
`include "gate_driver_params.svh"
// Overcurrent filter: condition must hold for the selected time before it counts
module oc_deglitch #(
	parameter int CW = 8
) (
	// Clock and reset
	input  wire logic       clk_in,
	input  wire logic       rst_in,
	// Filter
	input  wire logic       raw_in,
	input  wire logic [1:0] sel_in,
	output logic            hit_out
);
	logic [CW-1:0] cnt_reg;
	logic [CW-1:0] limit;

	// Filter length from the deglitch code, rounded up to whole cycles
	always_comb begin
		unique case (sel_in)
			2'h0: limit = CW'(`NS_TO_CYC(`DEG0_NS));
			2'h1: limit = CW'(`NS_TO_CYC(`DEG1_NS));
			2'h2: limit = CW'(`NS_TO_CYC(`DEG2_NS));
			2'h3: limit = CW'(`NS_TO_CYC(`DEG3_NS));
		endcase
	end

	// A single drop of the condition restarts the count
	always_ff @(posedge clk_in or posedge rst_in) begin
		if (rst_in) begin
			cnt_reg <= '0;
		end else if (!raw_in) begin
			cnt_reg <= '0;
		end else if (cnt_reg < limit) begin
			cnt_reg <= cnt_reg + CW'(1);
		end
	end

	assign hit_out = raw_in && (cnt_reg >= limit);
endmodule : oc_deglitch
`default_nettype wire

// *** rtl/gate_driver_settings.sv ***
`timescale 1ns/10ps
`default_nettype none
`include "gate_driver_params.svh"
// Gate-driver settings register and the protection logic it steers
module gate_driver_settings #(
	parameter int RETRY_SHORT = `RETRY_SHORT_CYC,
	parameter int RETRY_LONG  = `RETRY_LONG_CYC
) (
	// Clock and reset
	input  wire logic        clk_in,
	input  wire logic        rst_in,
	// Register port
	input  wire logic [7:0]  reg_addr_in,
	input  wire logic        reg_wr_in,
	input  wire logic [31:0] reg_wdata_in,
	output logic      [31:0] reg_rdata_out,
	// Fault sense pins
	input  wire logic        overcurrent_in,
	input  wire logic        overvoltage_20_in,
	input  wire logic        overvoltage_32_in,
	input  wire logic        overtemp_warn_in,
	input  wire logic        oc_clear_in,
	// Controls to the analog stage
	output logic      [1:0]  slew_rate_out,
	output logic             overcurrent_trip_level_out,
	output logic             demag_threshold_low_side_out,
	output logic             demag_threshold_high_side_out,
	output logic             sync_rectification_enable_out,
	output logic             async_rectification_enable_out,
	output logic      [1:0]  current_sense_gain_out,
	// Status
	output logic             outputs_enable_out,
	output logic             overcurrent_seen_out,
	output logic             fault_indicator_n_out
);
	import gate_driver_pkg::*;

	logic [31:0]  gate_driver_settings_one_reg;
	oc_response_t overcurrent_fault_response;
	logic         overcurrent_retry_interval;
	logic         supply_overvoltage_guard_enable;
	logic         supply_overvoltage_threshold_select;
	logic         overtemp_warning_report_enable;
	logic [1:0]   overcurrent_deglitch_time;
	logic [2:0]   oc_sync_reg, ov20_sync_reg, ov32_sync_reg, otw_sync_reg;
	logic         oc_lvl, ov20_lvl, ov32_lvl, otw_lvl;
	logic         oc_hit;
	oc_state_t    oc_state_reg;
	logic [31:0]  retry_cnt_reg;
	logic         seen_reg;
	logic         ov_active;

	// Register write; every bit is kept, reserved and parity included
	always_ff @(posedge clk_in or posedge rst_in) begin
		if (rst_in) begin
			gate_driver_settings_one_reg <= `GDS1_RESET;
		end else if (reg_wr_in && reg_addr_in == `GDS1_OFFSET) begin
			gate_driver_settings_one_reg <= reg_wdata_in;
		end
	end

	// Read back; unmapped addresses read zero
	always_ff @(posedge clk_in or posedge rst_in) begin
		if (rst_in) begin
			reg_rdata_out <= 32'h00000000;
		end else if (reg_addr_in == `GDS1_OFFSET) begin
			reg_rdata_out <= gate_driver_settings_one_reg;
		end else begin
			reg_rdata_out <= 32'h00000000;
		end
	end

	// Field decode; stored value feeds logic the cycle after the write
	assign overcurrent_fault_response = oc_response_t'(gate_driver_settings_one_reg[`GDS1_MODE_LSB +: 2]);
	assign overcurrent_retry_interval = gate_driver_settings_one_reg[`GDS1_RETRY_BIT];
	assign overcurrent_deglitch_time = gate_driver_settings_one_reg[`GDS1_DEG_LSB +: 2];
	assign supply_overvoltage_guard_enable = gate_driver_settings_one_reg[`GDS1_SUPPLY_OVERVOLTAGE_GUARD_ENABLE_BIT];
	assign supply_overvoltage_threshold_select = gate_driver_settings_one_reg[`GDS1_SUPPLY_OVERVOLTAGE_THRESHOLD_SELECT_BIT];
	assign overtemp_warning_report_enable = gate_driver_settings_one_reg[`GDS1_OVERTEMP_WARNING_REPORT_ENABLE_BIT];

	// Analog controls straight from the register flops
	assign slew_rate_out = gate_driver_settings_one_reg[`GDS1_SLEW_LSB +: 2];
	assign overcurrent_trip_level_out = gate_driver_settings_one_reg[`GDS1_LVL_BIT];
	assign demag_threshold_low_side_out = gate_driver_settings_one_reg[`GDS1_DMAG_LS_BIT];
	assign demag_threshold_high_side_out = gate_driver_settings_one_reg[`GDS1_DMAG_HS_BIT];
	assign sync_rectification_enable_out = gate_driver_settings_one_reg[`GDS1_SYNC_BIT];
	assign async_rectification_enable_out = gate_driver_settings_one_reg[`GDS1_ASYNC_BIT];
	assign current_sense_gain_out = gate_driver_settings_one_reg[`GDS1_GAIN_LSB +: 2];

	// Pins are asynchronous: three stages, a change counts when stages two and three agree
	always_ff @(posedge clk_in or posedge rst_in) begin
		if (rst_in) begin
			oc_sync_reg   <= 3'h0;
			ov20_sync_reg <= 3'h0;
			ov32_sync_reg <= 3'h0;
			otw_sync_reg  <= 3'h0;
			oc_lvl        <= 1'b0;
			ov20_lvl      <= 1'b0;
			ov32_lvl      <= 1'b0;
			otw_lvl       <= 1'b0;
		end else begin
			oc_sync_reg   <= {oc_sync_reg[1:0], overcurrent_in};
			ov20_sync_reg <= {ov20_sync_reg[1:0], overvoltage_20_in};
			ov32_sync_reg <= {ov32_sync_reg[1:0], overvoltage_32_in};
			otw_sync_reg  <= {otw_sync_reg[1:0], overtemp_warn_in};
			if (oc_sync_reg[1] == oc_sync_reg[2]) oc_lvl <= oc_sync_reg[2];
			if (ov20_sync_reg[1] == ov20_sync_reg[2]) ov20_lvl <= ov20_sync_reg[2];
			if (ov32_sync_reg[1] == ov32_sync_reg[2]) ov32_lvl <= ov32_sync_reg[2];
			if (otw_sync_reg[1] == otw_sync_reg[2]) otw_lvl <= otw_sync_reg[2];
		end
	end

	// Deglitch the overcurrent comparator
	oc_deglitch #(
		.CW(8)
	) u_deglitch (
		.clk_in (clk_in),
		.rst_in (rst_in),
		.raw_in (oc_lvl),
		.sel_in (overcurrent_deglitch_time),
		.hit_out(oc_hit)
	);

	// Overcurrent response state machine
	always_ff @(posedge clk_in or posedge rst_in) begin
		if (rst_in) begin
			oc_state_reg  <= OC_ST_RUN;
			retry_cnt_reg <= 32'h00000000;
		end else begin
			unique case (oc_state_reg)
				OC_ST_RUN: begin
					if (oc_hit && overcurrent_fault_response == OC_LATCHED) begin
						oc_state_reg <= OC_ST_LATCHED;
					end else if (oc_hit && overcurrent_fault_response == OC_RETRY) begin
						oc_state_reg  <= OC_ST_WAIT;
						retry_cnt_reg <= 32'h00000000;
					end
				end
				OC_ST_LATCHED: begin
					// Only an explicit clear releases a latched fault
					if (oc_clear_in) oc_state_reg <= OC_ST_RUN;
				end
				OC_ST_WAIT: begin
					// Interval chosen when the wait ends, so a rewrite mid-wait applies
					if (retry_cnt_reg >= 32'(overcurrent_retry_interval ? RETRY_LONG : RETRY_SHORT) - 32'h1) begin
						oc_state_reg <= OC_ST_RUN;
					end else begin
						retry_cnt_reg <= retry_cnt_reg + 32'h1;
					end
				end
				default: begin
					// Upset one-hot code: fall back to running rather than hang
					oc_state_reg <= OC_ST_RUN;
				end
			endcase
		end
	end

	// Sticky record; a new event wins over the clear in the same cycle
	always_ff @(posedge clk_in or posedge rst_in) begin
		if (rst_in) begin
			seen_reg <= 1'b0;
		end else if (oc_hit && overcurrent_fault_response != OC_IGNORE) begin
			seen_reg <= 1'b1;
		end else if (oc_clear_in) begin
			seen_reg <= 1'b0;
		end
	end

	// Overvoltage guard with threshold select
	assign ov_active = supply_overvoltage_guard_enable &&
		(supply_overvoltage_threshold_select ? ov20_lvl : ov32_lvl);

	// Report-only and ignore modes never reach the outputs
	assign outputs_enable_out = (oc_state_reg == OC_ST_RUN) && !ov_active;
	assign overcurrent_seen_out = seen_reg;
	assign fault_indicator_n_out = !(seen_reg || oc_state_reg != OC_ST_RUN || ov_active ||
		(overtemp_warning_report_enable && otw_lvl));
endmodule : gate_driver_settings
`default_nettype wire

// *** bench/gate_driver_settings_sva.sv ***
`timescale 1ns/10ps
`default_nettype none
module gate_driver_settings_chk #(
	parameter int RETRY_SHORT = 20,
	parameter int RETRY_LONG  = 40
) (
	// Clock, reset, register port
	input wire logic clk_in, rst_in, reg_wr_in,
	input wire logic [7:0] reg_addr_in,
	input wire logic [31:0] reg_wdata_in, reg_rdata_out,
	// Pins and status
	input wire logic overcurrent_in, overvoltage_20_in, overvoltage_32_in, overtemp_warn_in, oc_clear_in,
	input wire logic overcurrent_trip_level_out, outputs_enable_out, overcurrent_seen_out, fault_indicator_n_out,
	input wire logic [1:0] current_sense_gain_out
);
	default clocking cb @(posedge clk_in); endclocking
	default disable iff (rst_in);
	logic [31:0] sh_reg;
	int          off_reg;
	int          lim;
	// Shadow copy of the settings so mode-dependent checks know the mode
	always_ff @(posedge clk_in or posedge rst_in) begin
		if (rst_in) sh_reg <= 32'h00228000;
		else if (reg_wr_in && reg_addr_in == 8'hAC) sh_reg <= reg_wdata_in;
	end
	// Length of the last stretch with the power stage off
	always_ff @(posedge clk_in or posedge rst_in) begin
		if (rst_in) off_reg <= 0;
		else off_reg <= outputs_enable_out ? 0 : off_reg + 1;
	end
	assign lim = sh_reg[11] ? RETRY_LONG : RETRY_SHORT;
	chk_field_apply: assert property (reg_wr_in && reg_addr_in == 8'hAC |=> {overcurrent_trip_level_out,
		current_sense_gain_out} == {$past(reg_wdata_in[10]), $past(reg_wdata_in[1:0])}) else $error("field late");
	chk_read_back: assert property ((reg_wr_in && reg_addr_in == 8'hAC) ##1 (!reg_wr_in && reg_addr_in == 8'hAC)
		|=> reg_rdata_out == $past(reg_wdata_in, 2)) else $error("read back differs");
	chk_unmapped_zero: assert property (reg_addr_in != 8'hAC |=> reg_rdata_out == 32'h0) else $error("bad read");
	chk_ignore_quiet: assert property (sh_reg[9:8] == 2'h3 |-> !$rose(overcurrent_seen_out)) else $error("seen");
	chk_report_runs: assert property ($rose(overcurrent_seen_out) && sh_reg[9:8] == 2'h2 |-> outputs_enable_out)
		else $error("report mode cut outputs");
	chk_retry_time: assert property ($rose(outputs_enable_out) && sh_reg[9:8] == 2'h1 && !sh_reg[18]
		|-> off_reg inside {[lim - 1 : lim + 2]}) else $error("retry length wrong");
	chk_latch_holds: assert property (!outputs_enable_out && sh_reg[9:8] == 2'h0 && !oc_clear_in && !sh_reg[18]
		|=> !outputs_enable_out) else $error("latched fault released");
	chk_otw_report: assert property ((sh_reg[16] && !sh_reg[18] && overtemp_warn_in) [*5]
		|-> !fault_indicator_n_out) else $error("warning not shown");
	chk_otw_mask: assert property (!sh_reg[16] && !sh_reg[18] && !overcurrent_seen_out && outputs_enable_out
		|-> fault_indicator_n_out) else $error("fault shown");
	chk_ov_cut: assert property ((sh_reg[18] && (sh_reg[19] ? overvoltage_20_in : overvoltage_32_in)) [*5]
		|-> !outputs_enable_out && !fault_indicator_n_out) else $error("overvoltage missed");
	cov_latched: cover property ($fell(outputs_enable_out) && sh_reg[9:8] == 2'h0);
	cov_retry: cover property ($rose(outputs_enable_out) && sh_reg[9:8] == 2'h1);
	cov_ov: cover property (sh_reg[18] && !outputs_enable_out);
endmodule : gate_driver_settings_chk
bind gate_driver_settings gate_driver_settings_chk #(.RETRY_SHORT(RETRY_SHORT), .RETRY_LONG(RETRY_LONG)) i_chk (
	.clk_in, .rst_in, .reg_wr_in, .reg_addr_in, .reg_wdata_in, .reg_rdata_out, .overcurrent_in, .overvoltage_20_in,
	.overvoltage_32_in, .overtemp_warn_in, .oc_clear_in, .overcurrent_trip_level_out, .outputs_enable_out,
	.overcurrent_seen_out, .fault_indicator_n_out, .current_sense_gain_out);
`default_nettype wire

// *** bench/tb_gate_driver_settings.sv ***
`timescale 1ns/10ps
`default_nettype none
module tb_gate_driver_settings;
	logic clk_in = 0, rst_in = 1, reg_wr_in = 0, overcurrent_in = 0, oc_clear_in = 0, look_v = 0, look_d = 0;
	logic overvoltage_20_in = 0, overvoltage_32_in = 0, overtemp_warn_in = 0;
	logic [7:0] reg_addr_in = 8'h00, a;
	logic [31:0] reg_wdata_in = 32'h0, reg_rdata_out, d, obs;
	logic [1:0] slew_rate_out, current_sense_gain_out, sel;
	logic overcurrent_trip_level_out, demag_threshold_low_side_out, demag_threshold_high_side_out;
	logic sync_rectification_enable_out, async_rectification_enable_out;
	logic outputs_enable_out, overcurrent_seen_out, fault_indicator_n_out;
	logic [31:0] exp_q[$];
	logic [1:0] sel_q[$];
	int mismatches = 0, total_checks = 0, cycles = 0, seed = 32'hc61e13b4;
	gate_driver_settings #(.RETRY_SHORT(20), .RETRY_LONG(40)) i_dut (.clk_in, .rst_in, .reg_addr_in, .reg_wr_in,
		.reg_wdata_in, .reg_rdata_out, .overcurrent_in, .overvoltage_20_in, .overvoltage_32_in, .overtemp_warn_in,
		.oc_clear_in, .slew_rate_out, .overcurrent_trip_level_out, .demag_threshold_low_side_out,
		.demag_threshold_high_side_out, .sync_rectification_enable_out, .async_rectification_enable_out,
		.current_sense_gain_out, .outputs_enable_out, .overcurrent_seen_out, .fault_indicator_n_out);
	always #50 clk_in = ~clk_in;
	task automatic check(input logic [31:0] seen, input logic [31:0] exp);
		total_checks++;
		if (seen !== exp) begin
			mismatches++;
			$display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
		end
	endtask : check
	task automatic test_done;
		$display("checks=%0d mismatches=%0d", total_checks, mismatches);
		if (mismatches == 0 && total_checks > 0) $display("Simulation passed");
		else $display("Simulation failed");
		$finish;
	endtask : test_done
	// Watcher samples on the falling edge, where the outputs launched by the rising edge have settled
	always @(negedge clk_in) begin
		if (look_d) begin
			sel = sel_q.pop_front();
			obs = (sel == 0) ? reg_rdata_out : (sel == 1) ? {29'h0, outputs_enable_out, overcurrent_seen_out,
				fault_indicator_n_out} : {23'h0, slew_rate_out, overcurrent_trip_level_out, demag_threshold_low_side_out,
				demag_threshold_high_side_out, sync_rectification_enable_out, async_rectification_enable_out,
				current_sense_gain_out};
			check(obs, exp_q.pop_front());
		end
		look_d <= look_v;
	end
	// Hang guard, far above the well under a thousand cycles the tests need
	always @(posedge clk_in) begin
		cycles++;
		if (cycles == 20000) begin
			mismatches++;
			test_done();
		end
	end
	// Views: 0 read data, 1 {enable, seen, fault_n}, 2 analog fields
	task automatic look(input logic [1:0] s, input logic [31:0] e, input logic [7:0] ad = 8'hAC);
		@(posedge clk_in); #1 reg_addr_in = ad; look_v = 1; sel_q.push_back(s); exp_q.push_back(e);
		@(posedge clk_in); #1 look_v = 0;
	endtask : look
	task automatic wr(input logic [7:0] ad, input logic [31:0] v);
		@(posedge clk_in); #1 reg_addr_in = ad; reg_wr_in = 1; reg_wdata_in = v;
		@(posedge clk_in); #1 reg_wr_in = 0;
	endtask : wr
	task automatic pin(input int p, input int v, input int n);
		@(posedge clk_in); #1 overvoltage_32_in = (p == 0) && v != 0; overvoltage_20_in = (p == 1) && v != 0;
		overtemp_warn_in = (p == 2) && v != 0; overcurrent_in = (p == 3) && v != 0;
		repeat (n) @(posedge clk_in);
	endtask : pin
	task automatic clr;
		@(posedge clk_in); #1 oc_clear_in = 1;
		@(posedge clk_in); #1 oc_clear_in = 0;
		look(1, 32'h5);
	endtask : clr
	// Tables: mode outcomes, deglitch codes, level-sense cases
	logic [31:0] mid[4] = '{32'h2, 32'h2, 32'h6, 32'h5}, aft[4] = '{32'h2, 32'h6, 32'h6, 32'h5};
	logic [31:0] lv_cfg[5] = '{32'h40200, 32'hC0200, 32'h200, 32'h10200, 32'h200};
	// Deglitch pulses for each code differ by one cycle: one just too short and one just long enough to trip the filter
	int lv_pin[5] = '{0, 1, 0, 2, 2}, dg_ok[4] = '{1, 5, 10, 15}, dg_hit[4] = '{2, 6, 11, 16};
	logic [31:0] lv_exp[5] = '{32'h0, 32'h0, 32'h5, 32'h4, 32'h5};
	initial begin
		repeat (12) @(posedge clk_in);
		#1 rst_in = 0;
		look(0, 32'h00228000); look(1, 32'h5); look(2, 32'h0);
		$display("test reset done");
		repeat (6) begin
			d = $random(seed);
			// Host keeps reserved bits at their reset values
			d = (d & ~32'h73F2C0C0) | 32'h00228000;
			d[18] = 1'b0;
			d[9:8] = 2'h3;
			a = 8'($random(seed));
			a = (a == 8'hAC) ? 8'hAD : a;
			wr(8'hAC, d);
			look(2, {23'h0, d[27:26], d[10], d[5], d[4], d[3], d[2], d[1:0]});
			wr(a, ~d); look(0, 32'h0, a); look(0, d);
		end
		$display("test fields done");
		for (int m = 0; m < 4; m++) begin
			wr(8'hAC, 32'h00228000 | (m << 8));
			pin(3, 1, 10); pin(3, 0, 0); look(1, mid[m]); repeat (30) @(posedge clk_in); look(1, aft[m]); clr;
		end
		wr(8'hAC, 32'h00228900); pin(3, 1, 10); pin(3, 0, 20); look(1, 32'h2);
		repeat (20) @(posedge clk_in); look(1, 32'h6); clr;
		$display("test modes done");
		for (int i = 0; i < 4; i++) begin
			wr(8'hAC, 32'h00228200 | (i << 12));
			pin(3, 1, dg_ok[i]); pin(3, 0, 8); look(1, 32'h5); pin(3, 1, dg_hit[i]); pin(3, 0, 8); look(1, 32'h6); clr;
		end
		for (int i = 0; i < 5; i++) begin
			wr(8'hAC, 32'h00228000 | lv_cfg[i]); pin(lv_pin[i], 1, 6); look(1, lv_exp[i]); pin(0, 0, 6); look(1, 32'h5);
		end
		$display("test protection done");
		// Second reset in mid-run must bring the written register back
		@(posedge clk_in);
		#1 rst_in = 1;
		repeat (3) @(posedge clk_in);
		#1 rst_in = 0;
		look(0, 32'h00228000);
		look(1, 32'h5);
		look(2, 32'h0);
		$display("test second reset done");
		// Let the watcher take the last note before the verdict
		repeat (2) @(posedge clk_in);
		check(32'(exp_q.size()), 32'h0);
		test_done();
	end
endmodule : tb_gate_driver_settings
`default_nettype wire
